// file: hw/fast_interrupt_ctrl_cfg.svh
// Purpose: Offsets, field positions, keys and reset values for the
//          pending, threshold and global status slice.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte addresses within the controller's APB window.
`ifndef FAST_INTERRUPT_CTRL_CFG_SVH
`define FAST_INTERRUPT_CTRL_CFG_SVH

`define PEND_LOW_OFS 12'h020
`define PEND_HIGH_OFS 12'h024
`define CUTOFF_OFS 12'h040
`define CONFIG_OFS 12'h048
`define SUMMARY_OFS 12'h04C
`define SYSCTL_OFS 12'hD10

`define PEND_LOW_MASK 32'hFFFF500C
`define PEND_HIGH_MASK 32'h0000007F
`define CUTOFF_MASK 8'hC0
`define CUTOFF_RST 8'h00
`define KEY_HI 31
`define KEY_LO 16
`define FIRST_UNLOCK_VALUE 16'hFA05
`define SECOND_UNLOCK_VALUE 16'hBCAF
`define RESET_UNLOCK_VALUE 16'hBEEF
`define SYSRST_BIT 7
`define SCTL_RST_BIT 31
`define DEPTH_ONE 8'h01
`define DEPTH_TWO 8'h03
`define DEPTH_NONE 8'h00
`define ACT_BIT 8
`define PEND_BIT 9
`define NUM_IRQ 39
`define ZERO32 32'h00000000

`endif

// file: hw/fast_interrupt_ctrl_pkg.sv
// Purpose: Shared types for the interrupt status slice.
// Assumes: Nothing is imported; users write the package name.
// Notes:   Types only; numbers live in the cfg header.
package fast_interrupt_ctrl_pkg;

  // One APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // Core-side service sequencing
  typedef enum logic [2:0] {
    NEST_IDLE = 3'h1,
    NEST_ONE = 3'h2,
    NEST_TWO = 3'h4
  } nest_state_t;

endpackage

// file: hw/irq_gate_cell.sv
// Purpose: One interrupt line: pending latch and threshold gate.
// Assumes: Sources pulse or hold irqIn; core acks by ackIn.
// Notes:   Set wins over the acknowledge in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "fast_interrupt_ctrl_cfg.svh"

module irq_gate_cell (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic irqIn,
  input wire logic ackIn,
  input wire logic enableIn,
  input wire logic [7:0] prioIn,
  input wire logic [7:0] cutoffIn,
  output logic pendingOut,
  output logic eligibleOut
);

  logic pending_ff;
  logic nxt_pending;
  wire logic cutoffOn;
  wire logic prioPass;

  // Hold pending until served; new event beats the ack
  assign nxt_pending = irqIn | (pending_ff & ~ackIn);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pending_ff <= 1'b0;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // Zero cutoff disables filtering entirely
  assign cutoffOn = (cutoffIn != 8'h00);
  // Lower priority value than the cutoff stays pending only
  assign prioPass = ~cutoffOn | (prioIn >= cutoffIn);
  assign pendingOut = pending_ff;
  assign eligibleOut = pending_ff & enableIn & prioPass;

endmodule
`default_nettype wire

// file: hw/nest_tracker.sv
// Purpose: Two-level service nesting tracker.
// Assumes: Core pulses takeIn on entry and retIn on return.
// Notes:   A third entry is refused; the stack is two deep.
`timescale 1ns/100ps
`default_nettype none
`include "fast_interrupt_ctrl_cfg.svh"

module nest_tracker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic takeIn,
  input wire logic retIn,
  output logic [7:0] depthOut,
  output logic canTakeOut
);

  fast_interrupt_ctrl_pkg::nest_state_t state_ff;
  fast_interrupt_ctrl_pkg::nest_state_t nxt_state;

  // Entry and return in one cycle cancel out at level one only; at idle the entry wins, at level two the return
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fast_interrupt_ctrl_pkg::NEST_IDLE: begin
        if (takeIn) nxt_state = fast_interrupt_ctrl_pkg::NEST_ONE;
      end
      fast_interrupt_ctrl_pkg::NEST_ONE: begin
        if (takeIn && !retIn) nxt_state = fast_interrupt_ctrl_pkg::NEST_TWO;
        else if (retIn && !takeIn)
          nxt_state = fast_interrupt_ctrl_pkg::NEST_IDLE;
      end
      fast_interrupt_ctrl_pkg::NEST_TWO: begin
        if (retIn) nxt_state = fast_interrupt_ctrl_pkg::NEST_ONE;
      end
      default: nxt_state = fast_interrupt_ctrl_pkg::NEST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= fast_interrupt_ctrl_pkg::NEST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Depth code as software sees it
  assign depthOut =
    (state_ff == fast_interrupt_ctrl_pkg::NEST_TWO) ? `DEPTH_TWO :
    (state_ff == fast_interrupt_ctrl_pkg::NEST_ONE) ? `DEPTH_ONE :
    `DEPTH_NONE;
  assign canTakeOut = (state_ff != fast_interrupt_ctrl_pkg::NEST_TWO);

endmodule
`default_nettype wire

// file: hw/irq_pending_threshold_status.sv
// Purpose: Pending status, priority cutoff, keyed system reset and
//          global status of the fast interrupt controller.
// Assumes: APB slave, zero wait states; sys_clk 200 MHz; sync reset.
// Notes:   Enable and priority state arrive as inputs from siblings.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fast_interrupt_ctrl_cfg.svh"

module irq_pending_threshold_status (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [38:0] irqReq,
  input wire logic [38:0] irqEnable,
  input wire logic [311:0] irqPrio,
  input wire logic irqAck,
  input wire logic irqReturn,
  output logic [38:0] irqEligible,
  output logic irqTakeOk,
  output logic sysResetReq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  fast_interrupt_ctrl_pkg::apb_req_t req;
  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  logic ready_ff;
  wire logic setupPh = req.sel & ~req.enable;
  // Writes commit at the access edge, where pready is sampled high, so
  // a transfer that never completes leaves every register untouched
  wire logic wrAccess = req.sel & req.enable & req.write & ready_ff;
  wire logic rdSetup = setupPh & ~req.write;
  wire logic hitLow = (req.addr == `PEND_LOW_OFS);
  wire logic hitHigh = (req.addr == `PEND_HIGH_OFS);
  wire logic hitCut = (req.addr == `CUTOFF_OFS);
  wire logic hitCfg = (req.addr == `CONFIG_OFS);
  wire logic hitSum = (req.addr == `SUMMARY_OFS);
  wire logic hitSctl = (req.addr == `SYSCTL_OFS);
  wire logic hitAny = hitLow | hitHigh | hitCut | hitCfg | hitSum | hitSctl;
  wire logic [15:0] keyIn = req.wdata[`KEY_HI:`KEY_LO];

  ////////////////////////////////////////////////////////////////////////
  // Per-line pending and gate

  logic [38:0] pendVec;
  logic [38:0] eligVec;
  logic [7:0] cutoff_ff;
  logic [38:0] ackVec;

  // The core's acknowledge clears every line eligible in that cycle
  assign ackVec = {39{irqAck}} & eligVec;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_IRQ; gi++) begin : g_line
      irq_gate_cell u_cell (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .irqIn(irqReq[gi]),
        .ackIn(ackVec[gi]),
        .enableIn(irqEnable[gi]),
        .prioIn(irqPrio[gi*8 +: 8]),
        .cutoffIn(cutoff_ff),
        .pendingOut(pendVec[gi]),
        .eligibleOut(eligVec[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Nesting

  logic [7:0] depth;
  logic canTake;

  nest_tracker u_nest (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .takeIn(irqAck),
    .retIn(irqReturn),
    .depthOut(depth),
    .canTakeOut(canTake)
  );

  ////////////////////////////////////////////////////////////////////////
  // Cutoff register

  logic [7:0] nxt_cutoff;
  // Writes touch only the two stored bits
  assign nxt_cutoff = (wrAccess & hitCut) ?
    (req.wdata[7:0] & `CUTOFF_MASK) : cutoff_ff;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cutoff_ff <= `CUTOFF_RST;
    end else begin
      cutoff_ff <= nxt_cutoff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Keyed system reset

  logic control_reg_reset_bit_ff;
  wire logic keyedRst = wrAccess & hitCfg & req.wdata[`SYSRST_BIT]
    & (keyIn == `RESET_UNLOCK_VALUE);
  wire logic sctlRst = wrAccess & hitSctl & req.wdata[`SCTL_RST_BIT];
  // One shared one-cycle request; the bit never stays set
  wire logic nxt_control_reg_reset_bit = keyedRst | sctlRst;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      control_reg_reset_bit_ff <= 1'b0;
    end else begin
      control_reg_reset_bit_ff <= nxt_control_reg_reset_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and summary

  wire logic anyActive = (depth != `DEPTH_NONE);
  wire logic anyPendEn = |(pendVec & irqEnable);
  logic [31:0] sumWord;
  always_comb begin
    sumWord = `ZERO32;
    sumWord[7:0] = depth;
    sumWord[`ACT_BIT] = anyActive;
    sumWord[`PEND_BIT] = anyPendEn;
  end

  // Config and control register read back as zero, key included
  wire logic [31:0] nxt_rdata =
    hitLow ? (pendVec[31:0] & `PEND_LOW_MASK) :
    hitHigh ? ({25'h0000000, pendVec[38:32]} & `PEND_HIGH_MASK) :
    hitCut ? {24'h000000, cutoff_ff} :
    hitSum ? sumWord :
    `ZERO32;

  logic [31:0] rdata_ff;
  logic err_ff;
  logic [38:0] elig_ff;
  logic take_ff;

  // Answer in the cycle after setup: no wait states
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_ff <= `ZERO32;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      elig_ff <= 39'h0000000000;
      take_ff <= 1'b0;
    end else begin
      rdata_ff <= rdSetup ? nxt_rdata : `ZERO32;
      ready_ff <= setupPh;
      err_ff <= setupPh & ~hitAny;
      elig_ff <= eligVec;
      take_ff <= canTake;
    end
  end

  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign irqEligible = elig_ff;
  assign irqTakeOk = take_ff;
  assign sysResetReq = control_reg_reset_bit_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_wrong_key_ignored: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (wrAccess && hitCfg && keyIn != `RESET_UNLOCK_VALUE)
      |=> !sysResetReq)
    else $error("reset taken with wrong key");
  a_keyed_reset_pulse: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (keyedRst ##1 !nxt_control_reg_reset_bit) |-> sysResetReq ##1 !sysResetReq)
    else $error("keyed reset request not one cycle");
  a_sctl_reset_same: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sctlRst |=> sysResetReq)
    else $error("control reset bit had no effect");
  a_cutoff_low_bits: assert property (@(posedge sys_clk)
    disable iff (!reset_n) cutoff_ff[5:0] == 6'h00)
    else $error("cutoff low bits stored");
  a_cutoff_write: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (wrAccess && hitCut) |=> cutoff_ff == ($past(pwdata[7:0]) & 8'hC0))
    else $error("cutoff write lost");
  a_read_low_mask: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (rdSetup && hitLow) |=> (prdata & ~32'hFFFF500C) == 32'h00000000)
    else $error("reserved pending bits set");
  a_read_high_mask: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (rdSetup && hitHigh) |=> prdata[31:7] == 25'h0000000)
    else $error("high pending reserved bits set");
  a_read_cfg_zero: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (rdSetup && hitCfg) |=> prdata == 32'h00000000)
    else $error("config read not zero");
  a_gate_blocks: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (cutoff_ff != 8'h00 && irqPrio[23:16] < cutoff_ff) |-> !eligVec[2])
    else $error("line served below cutoff");
  a_gate_off: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (cutoff_ff == 8'h00) |-> eligVec == (pendVec & irqEnable))
    else $error("zero cutoff still gated");
  a_depth_limit: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    depth == 8'h00 || depth == 8'h01 || depth == 8'h03)
    else $error("illegal nesting depth");
  a_active_flag: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sumWord[8] == (depth != 8'h00))
    else $error("active flag wrong");
  a_pend_flag: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sumWord[9] == |(pendVec & irqEnable))
    else $error("pending flag wrong");
  a_depth_code: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (depth == 8'h01 && irqAck && !irqReturn) |=> depth == 8'h03)
    else $error("second level not reported");

  // Bus answer timing and the write commit point
  a_ready_after_setup: assert property (@(posedge sys_clk)
    disable iff (!reset_n) setupPh |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (@(posedge sys_clk)
    disable iff (!reset_n) pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (setupPh && !hitAny) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");
  a_cutoff_hold: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    !(wrAccess && hitCut) |=> $stable(cutoff_ff))
    else $error("cutoff changed without a write");
  a_cut_read_zero: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (rdSetup && hitCut) |=> prdata[31:8] == 24'h000000
      && prdata[5:0] == 6'h00)
    else $error("cutoff reserved bits read back");
  a_reset_on_write: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !wrAccess |=> !sysResetReq)
    else $error("reset request without a write");

  // Service side: gating keeps lines pending, nesting stops at two
  a_pending_kept: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (pendVec[2] && !eligVec[2]) |=> pendVec[2])
    else $error("gated line lost its pending state");
  a_take_refused: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (depth == 8'h03) |=> !irqTakeOk)
    else $error("third level offered to the core");
  a_two_level_hold: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (depth == 8'h03 && !irqReturn) |=> depth == 8'h03)
    else $error("nesting left level two without return");

  // Summary word as software reads it
  a_sum_active_read: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (rdSetup && hitSum) |=> prdata[8] == ($past(depth) != 8'h00))
    else $error("active flag read wrong");
  a_sum_upper_zero: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    (rdSetup && hitSum) |=> prdata[31:10] == 22'h000000)
    else $error("summary reserved bits set");

  c_keyed_reset: cover property (@(posedge sys_clk) keyedRst);
  c_nest_two: cover property (@(posedge sys_clk) depth == 8'h03);
  c_gated_line: cover property (@(posedge sys_clk)
    pendVec[2] && irqEnable[2] && !eligVec[2]);
  c_wrong_key: cover property (@(posedge sys_clk)
    wrAccess && hitCfg && keyIn != `RESET_UNLOCK_VALUE);
  c_third_refused: cover property (@(posedge sys_clk)
    depth == 8'h03 && eligVec != 39'h0000000000);

endmodule
`default_nettype wire

// file: bench/core_model.sv
// Purpose: Processor core side of the interrupt service handshake.
// Assumes: Bench pulses takeCmd or retCmd for one cycle.
// Notes:   Never acks while the controller refuses a deeper level.
`timescale 1ns/100ps
`default_nettype none

module core_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic takeCmd,
  input wire logic retCmd,
  input wire logic [38:0] irqEligible,
  input wire logic irqTakeOk,
  output logic irqAck,
  output logic irqReturn
);
  ////////////////////////////////////////////////////////////////////////
  // One-cycle pulses; a take with nothing eligible is dropped, as a
  // real core would not vector without a request
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irqAck <= 1'b0;
      irqReturn <= 1'b0;
    end else begin
      irqAck <= takeCmd & irqTakeOk & (|irqEligible);
      irqReturn <= retCmd;
    end
  end
endmodule

`default_nettype wire

// file: bench/irq_pending_threshold_status_tb.sv
// Purpose: Self-checking bench for the pending and status slice.
// Assumes: APB slave answers when ready; core model on service side.
// Notes:   Reset requests are counted, never fed back to the design.
`timescale 1ns/100ps
`default_nettype none
`include "fast_interrupt_ctrl_cfg.svh"

module irq_pending_threshold_status_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [38:0] irqReq = '0;
  logic [38:0] irqEnable = '0;
  logic [311:0] irqPrio = '0;
  logic irqAck;
  logic irqReturn;
  logic [38:0] irqEligible;
  logic irqTakeOk;
  logic sysResetReq;
  logic takeCmd = 1'b0;
  logic retCmd = 1'b0;
  logic [31:0] d;
  logic e;
  int rstCnt = 0;
  int error_cnt = 0;
  int checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  irq_pending_threshold_status u_dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqReq(irqReq), .irqEnable(irqEnable),
    .irqPrio(irqPrio), .irqAck(irqAck), .irqReturn(irqReturn),
    .irqEligible(irqEligible), .irqTakeOk(irqTakeOk),
    .sysResetReq(sysResetReq));

  core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n),
    .takeCmd(takeCmd), .retCmd(retCmd), .irqEligible(irqEligible),
    .irqTakeOk(irqTakeOk), .irqAck(irqAck), .irqReturn(irqReturn));

  ////////////////////////////////////////////////////////////////////////
  // Count reset request pulses seen at clock edges
  always @(posedge sys_clk) begin
    if (sysResetReq === 1'b1) begin
      rstCnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; writes land at the ready edge, so two idle edges
  // let registered outputs settle before the caller compares them
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge sys_clk);
    end
    chk(n, 32'h0);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(d, exp);
  endtask

  // Pulse request or core command lines, then let the latch settle;
  // two edges first so enable changes reach the eligible register
  task automatic pulse(input logic [38:0] v, input logic t,
      input logic r);
    repeat (2) @(posedge sys_clk);
    irqReq <= v;
    takeCmd <= t;
    retCmd <= r;
    @(posedge sys_clk);
    irqReq <= '0;
    takeCmd <= 1'b0;
    retCmd <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic stop_test;
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(`PEND_LOW_OFS, 32'h00000000);
    rd(`PEND_HIGH_OFS, 32'h00000000);
    rd(`CUTOFF_OFS, 32'h00000000);
    rd(`SUMMARY_OFS, 32'h00000000);
    rd(`CONFIG_OFS, 32'h00000000);
    apb(1'b0, 12'h100, 32'h0);
    chk({d[30:0], e}, 32'h00000001);
    wr_ro: apb(1'b1, `PEND_LOW_OFS, 32'hFFFFFFFF);
    rd(`PEND_LOW_OFS, 32'h00000000);
    apb(1'b1, `CUTOFF_OFS, 32'hFFFFFFFF);
    rd(`CUTOFF_OFS, 32'h000000C0);
    apb(1'b1, `CUTOFF_OFS, 32'h00000040);
    rd(`CUTOFF_OFS, 32'h00000040);
    // Line 2 below the cutoff, line 3 above it
    irqEnable <= 39'h000000000C;
    irqPrio[31:24] <= 8'h80;
    pulse(39'h7FFFFFFFFF, 1'b0, 1'b0);
    rd(`PEND_LOW_OFS, 32'hFFFF500C);
    rd(`PEND_HIGH_OFS, 32'h0000007F);
    chk(irqEligible[31:0], 32'h00000008);
    apb(1'b1, `CUTOFF_OFS, 32'h00000000);
    chk(irqEligible[31:0], 32'h0000000C);
    rd(`SUMMARY_OFS, 32'h00000200);
    // First service level clears the eligible lines
    pulse('0, 1'b1, 1'b0);
    rd(`PEND_LOW_OFS, 32'hFFFF5000);
    rd(`SUMMARY_OFS, 32'h00000101);
    irqEnable <= 39'h000000100C;
    pulse('0, 1'b1, 1'b0);
    rd(`SUMMARY_OFS, 32'h00000103);
    chk({31'h0, irqTakeOk}, 32'h0);
    // A third request stays pending; depth does not grow
    irqEnable <= 39'h000000500C;
    pulse('0, 1'b1, 1'b0);
    rd(`SUMMARY_OFS, 32'h00000303);
    rd(`PEND_LOW_OFS, 32'hFFFF4000);
    pulse('0, 1'b0, 1'b1);
    rd(`SUMMARY_OFS, 32'h00000301);
    pulse('0, 1'b0, 1'b1);
    rd(`SUMMARY_OFS, 32'h00000200);
    // Keyed reset trigger and the shared control register path
    apb(1'b1, `CONFIG_OFS, 32'hFA050080);
    chk(rstCnt, 32'h0);
    apb(1'b1, `CONFIG_OFS, 32'hBCAF0080);
    chk(rstCnt, 32'h0);
    apb(1'b1, `CONFIG_OFS, 32'hBEEF0000);
    chk(rstCnt, 32'h0);
    apb(1'b1, `CONFIG_OFS, 32'hBEEF0080);
    chk(rstCnt, 32'h1);
    rd(`CONFIG_OFS, 32'h00000000);
    apb(1'b1, `SYSCTL_OFS, 32'h80000000);
    chk(rstCnt, 32'h2);
    stop_test();
  end
endmodule

`default_nettype wire
